/* File: hdl/ulef_pkg.sv */
// package for the serial line event flag block: layout, offsets, constants
package ulef_pkg;

   // register word offsets (byte addresses, one aligned word each)
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CLEAR = 8'h04;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
   localparam logic [7:0] ADDR_CTRL_THREE = 8'h0c;
   localparam logic [7:0] ADDR_TIMEOUT = 8'h10;
   localparam logic [7:0] ADDR_EVENT = 8'h14;
   localparam logic [7:0] ADDR_MASK = 8'h18;

   // status / clear field positions
   localparam int BIT_RTO = 11;
   localparam int BIT_CTS = 10;
   localparam int BIT_CTSCHG = 9;
   localparam int BIT_LINBRK = 8;
   // control field positions
   localparam int BIT_LBD_IE = 6;
   localparam int BIT_CTS_EN = 9;
   localparam int BIT_CTS_IE = 10;
   localparam int BIT_RX_EN = 2;

   // event register layout: bit0 cts change, bit1 lin break, bit2 timeout
   localparam int EV_CTS = 0;
   localparam int EV_LIN = 1;
   localparam int EV_RTO = 2;

   // timeout: gap must exceed the value by more than this many sample ticks
   localparam logic [3:0] RTO_MARGIN = 4'h2;

   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [23:0] RST_TIMEOUT = 24'h00_0000;

   // control bundle carried from the register file to the flag logic
   typedef struct packed {
      logic cts_en;
      logic cts_ie;
      logic lbd_ie;
      logic rx_en;
   } ulef_ctrl_s;

   // software access bundle
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ulef_bus_s;

endpackage : ulef_pkg

/* File: hdl/ulef_flags.sv */
// line event flags: clear-to-send mirror and change, lin break, rx timeout
//
// Function
// [RULE1] status cts bit is the inverse of the synchronised active-low input
// [RULE2] without flow control, cts bit and its change flag read zero
// [RULE3] cts change flag sets on any input edge while cts enable is set
// [RULE4] cts change flag holds until software writes one to its clear bit
// [RULE5] interrupt while cts change flag and cts irq enable are both one
// [RULE6] lin break flag sets when the break detector reports a break
// [RULE7] lin break flag holds until software writes its clear bit
// [RULE8] interrupt while lin break flag and lin irq enable are both one
// [RULE9] without lin support, lin break flag reads zero
// [RULE10] timeout already elapsed when receiver enabled sets timeout flag
// [RULE11] without timeout feature, timeout flag reads zero
// [RULE12] timeout flag sets only when gap exceeds value plus two samples
// [RULE13] counter runs with receiver off; flag sets only with receiver on
// [RULE14] cts input passes two flip-flops before any use
`timescale 1ns/10ps
module ulef_flags #(
   parameter bit HAS_FLOW = 1'b1,
   parameter bit HAS_LIN = 1'b1,
   parameter bit HAS_RTO = 1'b1,
   parameter int RTO_W = 24
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire ulef_pkg::ulef_bus_s bus,
   output logic [31:0] rdata,
   input wire logic clear_to_send_n,
   input wire logic lin_break_detect,
   input wire logic sample_tick,
   input wire logic char_received,
   output logic cts_level,
   output logic irq
);
   import ulef_pkg::*;

   logic cts_meta;
   logic cts_sync;
   logic cts_prev;
   logic cts_change_flag;
   logic lin_break_flag;
   logic receive_timeout_flag;
   logic [31:0] control_reg_two;
   logic [31:0] control_reg_three;
   logic [RTO_W-1:0] receive_timeout_value_reg;
   logic [RTO_W+1:0] idle_cnt;
   logic [2:0] event_status;
   logic [2:0] event_mask;
   logic [2:0] ev_prev;
   logic rto_armed;
   logic rx_en_prev;
   ulef_ctrl_s ctl;

   // one-hot register decode, used for writes and reads alike
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   wire wr_clear = bus.wr && hit(bus.addr, ADDR_CLEAR);
   wire wr_two = bus.wr && hit(bus.addr, ADDR_CTRL_TWO);
   wire wr_three = bus.wr && hit(bus.addr, ADDR_CTRL_THREE);
   wire wr_tmo = bus.wr && hit(bus.addr, ADDR_TIMEOUT);
   wire wr_mask = bus.wr && hit(bus.addr, ADDR_MASK);
   wire rd_event = bus.rd && hit(bus.addr, ADDR_EVENT);

   assign ctl.cts_en = control_reg_three[BIT_CTS_EN];
   assign ctl.cts_ie = control_reg_three[BIT_CTS_IE];
   assign ctl.lbd_ie = control_reg_two[BIT_LBD_IE];
   assign ctl.rx_en = control_reg_three[BIT_RX_EN];

   // clear-to-send synchroniser; only cts_sync feeds logic
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cts_meta <= 1'b1;
         cts_sync <= 1'b1;
         cts_prev <= 1'b1;
      end
      else
      begin
         cts_meta <= clear_to_send_n;
         cts_sync <= cts_meta; // see [RULE14]
         cts_prev <= cts_sync;
      end
   end

   // mirror and edge; features absent force zero
   wire cts_bit = HAS_FLOW & ~cts_sync; // see [RULE1] see [RULE2]
   wire cts_edge = HAS_FLOW & (cts_sync ^ cts_prev) & ctl.cts_en; // see [RULE3]
   wire lin_set = HAS_LIN & lin_break_detect; // see [RULE6] see [RULE9]
   wire clr_cts = wr_clear & bus.wdata[BIT_CTSCHG];
   wire clr_lin = wr_clear & bus.wdata[BIT_LINBRK];
   wire clr_rto = wr_clear & bus.wdata[BIT_RTO];
   assign cts_level = cts_bit;

   // idle gap counter: threshold is value plus margin, strictly exceeded
   wire [RTO_W+1:0] rto_limit = {2'b00, receive_timeout_value_reg}
      + {{(RTO_W-2){1'b0}}, RTO_MARGIN};
   wire rto_elapsed = HAS_RTO & (idle_cnt > rto_limit); // see [RULE12]
   wire rto_set = rto_armed & rto_elapsed & ctl.rx_en; // see [RULE13]
   wire rx_rise = ctl.rx_en & ~rx_en_prev;

   // counter keeps running whatever the receiver enable; saturates at top
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         idle_cnt <= '0;
      else if (char_received)
         idle_cnt <= '0;
      else if (sample_tick && !(&idle_cnt))
         idle_cnt <= idle_cnt + 1'b1; // see [RULE13]
   end

   // armed once per gap so one idle period gives one timeout event;
   // stays armed across receiver-off so enabling late still fires
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rto_armed <= 1'b0;
         rx_en_prev <= 1'b0;
      end
      else
      begin
         rx_en_prev <= ctl.rx_en;
         if (char_received)
            rto_armed <= 1'b1;
         else if (rto_set)
            rto_armed <= 1'b0; // see [RULE10]
      end
   end

   // sticky flags; a set in the clear cycle wins over the clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cts_change_flag <= 1'b0;
         lin_break_flag <= 1'b0;
         receive_timeout_flag <= 1'b0;
      end
      else
      begin
         cts_change_flag <= cts_edge | (cts_change_flag & ~clr_cts); // see [RULE4]
         lin_break_flag <= lin_set | (lin_break_flag & ~clr_lin); // see [RULE7]
         receive_timeout_flag <= rto_set | (receive_timeout_flag & ~clr_rto);
      end
   end

   // software registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         control_reg_two <= RST_WORD;
         control_reg_three <= RST_WORD;
         receive_timeout_value_reg <= RST_TIMEOUT[RTO_W-1:0];
         event_mask <= RST_WORD[2:0];
      end
      else
      begin
         if (wr_two)
            control_reg_two <= bus.wdata;
         if (wr_three)
            control_reg_three <= bus.wdata;
         if (wr_tmo)
            receive_timeout_value_reg <= bus.wdata[RTO_W-1:0];
         if (wr_mask)
            event_mask <= bus.wdata[2:0];
      end
   end

   // event register: sticky, cleared by its read, new events win
   wire [2:0] ev_now = {receive_timeout_flag, lin_break_flag, cts_change_flag};
   wire [2:0] ev_rise = ev_now & ~ev_prev;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         event_status <= '0;
         ev_prev <= '0;
      end
      else
      begin
         ev_prev <= ev_now;
         event_status <= ev_rise | (event_status & {3{~rd_event}});
      end
   end

   // interrupt: flag and enable pairs, plus masked event register
   wire irq_cts = cts_change_flag & ctl.cts_ie; // see [RULE5]
   wire irq_lin = lin_break_flag & ctl.lbd_ie; // see [RULE8]
   assign irq = irq_cts | irq_lin | (|(event_status & event_mask));

   // read mux; timeout and cts status bits gated by feature presence
   wire [31:0] status_word = (32'(HAS_RTO & receive_timeout_flag) << BIT_RTO)
      | (32'(cts_bit) << BIT_CTS)
      | (32'(HAS_FLOW & cts_change_flag) << BIT_CTSCHG) // see [RULE2]
      | (32'(lin_break_flag) << BIT_LINBRK); // see [RULE9]
   wire [31:0] rd_mux =
      hit(bus.addr, ADDR_STATUS) ? status_word :
      hit(bus.addr, ADDR_CTRL_TWO) ? control_reg_two :
      hit(bus.addr, ADDR_CTRL_THREE) ? control_reg_three :
      hit(bus.addr, ADDR_TIMEOUT) ? 32'(receive_timeout_value_reg) :
      hit(bus.addr, ADDR_EVENT) ? {29'h0, event_status} :
      hit(bus.addr, ADDR_MASK) ? {29'h0, event_mask} : 32'h0000_0000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata <= RST_WORD;
      else if (bus.rd)
         rdata <= rd_mux;
      else
         rdata <= RST_WORD;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_line_edge;
      cts_sync != cts_prev;
   endsequence

   // three edges out of reset, so the sync chain holds real pin samples
   sequence s_reset_quiet;
      $past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3);
   endsequence

   // a read strobe on the register bus
   sequence s_read_strobe;
      bus.rd;
   endsequence

   // held against the pin two edges back, not against the mirror's own wire
   a_cts_mirror: assert property (s_reset_quiet
      |-> cts_level == (HAS_FLOW & ~$past(clear_to_send_n, 2))) // see [RULE1]
      else $error("cts status not inverse of input");
   a_cts_absent: assert property (!HAS_FLOW |-> !cts_level && !cts_change_flag) // see [RULE2]
      else $error("cts bits not zero without flow control");
   a_cts_edge_sets: assert property (s_line_edge ##0 (ctl.cts_en && HAS_FLOW)
      |=> cts_change_flag) // see [RULE3]
      else $error("cts edge did not set change flag");
   a_cts_no_enable: assert property (!cts_change_flag && !cts_edge
      |=> !cts_change_flag) // see [RULE3]
      else $error("cts change flag set without enabled edge");
   a_cts_sticky: assert property (cts_change_flag && !clr_cts
      |=> cts_change_flag) // see [RULE4]
      else $error("cts change flag lost without clear");
   a_cts_clear: assert property (clr_cts && !cts_edge |=> !cts_change_flag) // see [RULE4]
      else $error("cts change flag not cleared");
   a_cts_irq: assert property (cts_change_flag && ctl.cts_ie |-> irq) // see [RULE5]
      else $error("cts interrupt missing");
   a_lin_sets: assert property (lin_break_detect && HAS_LIN
      |=> lin_break_flag) // see [RULE6]
      else $error("lin break not flagged");
   a_lin_sticky: assert property (lin_break_flag && !clr_lin
      |=> lin_break_flag) // see [RULE7]
      else $error("lin break flag lost");
   a_lin_irq: assert property (lin_break_flag && ctl.lbd_ie |-> irq) // see [RULE8]
      else $error("lin interrupt missing");
   a_lin_absent: assert property (!HAS_LIN |-> !lin_break_flag) // see [RULE9]
      else $error("lin flag set without lin support");
   a_rto_absent: assert property (!HAS_RTO |-> !receive_timeout_flag) // see [RULE11]
      else $error("timeout flag set without feature");
   a_rto_gated: assert property ($rose(receive_timeout_flag)
      |-> $past(ctl.rx_en) && $past(idle_cnt) > $past(rto_limit)) // see [RULE12]
      else $error("timeout flag set too early or with receiver off");
   a_rto_late_en: assert property (rx_rise && rto_armed && rto_elapsed
      |=> receive_timeout_flag) // see [RULE10]
      else $error("elapsed timeout not flagged on receiver enable");

   // sync depth: exactly two flops between pin and logic
   a_sync_depth: assert property (s_reset_quiet
      |-> cts_sync == $past(clear_to_send_n, 2)) // see [RULE14]
      else $error("cts sync chain depth wrong");

   // clears of the other two flags
   a_lin_clear: assert property (clr_lin && !lin_set
      |=> !lin_break_flag) // see [RULE7]
      else $error("lin break flag not cleared");
   a_rto_clear: assert property (clr_rto && !rto_set
      |=> !receive_timeout_flag)
      else $error("timeout flag not cleared");

   // receiver off: the counter may run, the flag must not rise
   a_rto_rx_off: assert property (!ctl.rx_en && !receive_timeout_flag
      |=> !receive_timeout_flag) // see [RULE13]
      else $error("timeout flag set with receiver off");

   // a gap not beyond value plus margin leaves the flag down
   a_rto_equal_gap: assert property (idle_cnt <= rto_limit
      && !receive_timeout_flag |=> !receive_timeout_flag) // see [RULE12]
      else $error("timeout flag set on too short a gap");

   // interrupt line is quiet when no source is pending
   a_irq_quiet: assert property (!cts_change_flag && !lin_break_flag
      && !(|(event_status & event_mask)) |-> !irq) // see [RULE5] see [RULE8]
      else $error("interrupt without pending source");

   // read data is zero outside the reply cycle
   a_rdata_idle: assert property (!bus.rd |=> rdata == 32'h0000_0000)
      else $error("read data not zero outside reply");

   // reply carries the word addressed one cycle earlier
   a_rdata_reply: assert property (s_read_strobe |=> rdata == $past(rd_mux))
      else $error("read data not the addressed word");

   // event register: a read with no new event empties it
   a_ev_read_clr: assert property (rd_event && ev_rise == 3'b000
      |=> event_status == 3'b000)
      else $error("event register not cleared by read");

   // event register: each flag rise is caught even during a read
   a_ev_capture: assert property (ev_rise != 3'b000
      |=> (event_status & $past(ev_rise)) == $past(ev_rise))
      else $error("flag rise not captured in event register");

endmodule : ulef_flags

/* File: sim/ulef_node.sv */
// remote serial node model: flow-control pin, break and sampling strobes
`timescale 1ns/10ps
module ulef_node
(
   input wire logic clk,
   output logic clear_to_send_n,
   output logic lin_break_detect,
   output logic sample_tick,
   output logic char_received
);
   logic [1:0] div = 2'h0;
   initial
   begin
      clear_to_send_n = 1'b1;
      lin_break_detect = 1'b0;
      char_received = 1'b0;
   end
   // free-running sample strobe, one tick every fourth cycle
   always_ff @(posedge clk) div <= div + 2'h1;
   assign sample_tick = (div == 2'h3);
   // pin moves just after an edge and then holds as a level
   task automatic set_cts(input logic v);
      @(posedge clk);
      clear_to_send_n <= v;
   endtask : set_cts
   // detector and receiver report with one-cycle pulses
   task automatic pulse_break;
      @(posedge clk);
      lin_break_detect <= 1'b1;
      @(posedge clk);
      lin_break_detect <= 1'b0;
   endtask : pulse_break
   task automatic pulse_char;
      @(posedge clk);
      char_received <= 1'b1;
      @(posedge clk);
      char_received <= 1'b0;
   endtask : pulse_char
endmodule : ulef_node

/* File: sim/tb_top.sv */
// self-checking bench for the line event flag block
`timescale 1ns/10ps
module tb_top;
   import ulef_pkg::*;
   logic clk;
   logic rst_n;
   ulef_bus_s bus;
   logic [31:0] rdata, rdata0, rd_v, rd_v0;
   logic cts_n, lbd, tick, chr, cts_lvl, cts_lvl0, irq, irq0;
   int n_fail = 0;
   int total_checks = 0;
   ulef_node node (.clk(clk), .clear_to_send_n(cts_n),
      .lin_break_detect(lbd), .sample_tick(tick), .char_received(chr));
   ulef_flags dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .clear_to_send_n(cts_n), .lin_break_detect(lbd), .sample_tick(tick),
      .char_received(chr), .cts_level(cts_lvl), .irq(irq));
   // second copy built without the optional features, same stimulus
   ulef_flags #(.HAS_FLOW(1'b0), .HAS_LIN(1'b0), .HAS_RTO(1'b0)) dut_bare
      (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata0),
      .clear_to_send_n(cts_n), .lin_break_detect(lbd), .sample_tick(tick),
      .char_received(chr), .cts_level(cts_lvl0), .irq(irq0));
   // clock generation
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr_reg
   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      rd_v = rdata;
      rd_v0 = rdata0;
   endtask : rd_reg
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic t_reset;
      rd_reg(ADDR_STATUS);
      chk(rd_v, RST_WORD);
      chk({31'h0, cts_lvl}, 32'h0);
      rd_reg(8'h20);
      chk(rd_v, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_cts;
      node.set_cts(1'b0);
      cyc(5);
      chk({31'h0, cts_lvl}, 32'h1);
      chk({31'h0, cts_lvl0}, 32'h0);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h1 << BIT_CTS);
      wr_reg(ADDR_CTRL_THREE, (32'h1 << BIT_CTS_EN) | (32'h1 << BIT_CTS_IE));
      node.set_cts(1'b1);
      cyc(5);
      chk({31'h0, cts_lvl}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, irq0}, 32'h0);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h1 << BIT_CTSCHG);
      chk(rd_v0, 32'h0);
      rd_reg(ADDR_EVENT);
      chk(rd_v, 32'h1 << EV_CTS);
      chk({31'h0, irq}, 32'h1);
      wr_reg(ADDR_CLEAR, 32'h1 << BIT_CTSCHG);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // flag set but its enable off: the line must stay quiet
      wr_reg(ADDR_CTRL_THREE, 32'h1 << BIT_CTS_EN);
      node.set_cts(1'b0);
      cyc(5);
      rd_reg(ADDR_EVENT);
      chk({31'h0, irq}, 32'h0);
      rd_reg(ADDR_STATUS);
      chk(rd_v, (32'h1 << BIT_CTS) | (32'h1 << BIT_CTSCHG));
      wr_reg(ADDR_CTRL_THREE, 32'h0);
      wr_reg(ADDR_CLEAR, 32'h1 << BIT_CTSCHG);
      node.set_cts(1'b1);
      cyc(5);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h0);
      $display("test cts done");
   endtask : t_cts
   // the masked event bit alone drives irq until the event read empties it
   task automatic t_lin;
      wr_reg(ADDR_MASK, 32'h1 << EV_LIN);
      node.pulse_break();
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, irq0}, 32'h0);
      rd_reg(ADDR_EVENT);
      chk(rd_v, 32'h1 << EV_LIN);
      chk({31'h0, irq}, 32'h0);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h1 << BIT_LINBRK);
      chk(rd_v0, 32'h0);
      wr_reg(ADDR_MASK, 32'h0);
      wr_reg(ADDR_CTRL_TWO, 32'h1 << BIT_LBD_IE);
      cyc(1);
      chk({31'h0, irq}, 32'h1);
      wr_reg(ADDR_CLEAR, 32'h1 << BIT_LINBRK);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("test lin done");
   endtask : t_lin
   // value 5: a gap of more than 7 ticks is needed, ticks come every 4 cycles
   task automatic t_rto;
      wr_reg(ADDR_TIMEOUT, 32'h5);
      node.pulse_char();
      cyc(60);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h0);
      wr_reg(ADDR_CTRL_THREE, 32'h1 << BIT_RX_EN);
      cyc(2);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h1 << BIT_RTO);
      chk(rd_v0, 32'h0);
      wr_reg(ADDR_CLEAR, 32'h1 << BIT_RTO);
      rd_reg(ADDR_EVENT);
      node.pulse_char();
      cyc(20);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h0);
      cyc(16);
      rd_reg(ADDR_STATUS);
      chk(rd_v, 32'h1 << BIT_RTO);
      $display("test timeout done");
   endtask : t_rto
   // watchdog so that a stuck run still reaches the verdict
   initial
   begin
      #100000;
      n_fail++;
      $display("[ERR] %0t run limit reached", $time);
      final_report();
   end
   // main sequence
   initial
   begin
      rst_n = 1'b0;
      bus = '{addr: 8'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_cts();
      t_lin();
      t_rto();
      final_report();
   end
endmodule : tb_top
